/* include/pcs_pkg.sv */
// Purpose: Types of the clock source select block.
// Assumes: pcs_regs.svh on the include path.
// Notes:   All state of the top travels as one packed struct.
`include "pcs_regs.svh"

package pcs_pkg;

  // ----------------------------------------------------------------------
  // Unlock sequence states
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    PCS_LOCKED = 4'h1,
    PCS_KEY1_SEEN = 4'h2,
    PCS_KEY2_SEEN = 4'h4,
    PCS_OPEN = 4'h8
  } pcs_lock_t;

  // Candidate clock sources, sampled levels
  typedef struct packed {
    logic xtal_main;
    logic xtal_32k;
    logic bus_clk;
    logic pll;
    logic osc_22m;
    logic ext_trig;
    logic osc_10k;
  } pcs_src_t;

  // Selected clocks for the peripherals
  typedef struct packed {
    logic timer0;
    logic adc;
    logic watchdog;
    logic pwm45;
    logic pwm67;
    logic freq_div;
    logic audio;
  } pcs_clk_t;

  // APB answer
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } pcs_apb_rsp_t;

  // Whole state of the top module
  typedef struct packed {
    logic [31:0] sel1;
    logic [31:0] sel2;
    pcs_lock_t lock;
    logic [9:0] div_cnt;
    logic div_clk;
    pcs_clk_t clk;
    pcs_apb_rsp_t rsp;
  } pcs_state_t;

endpackage : pcs_pkg

/* include/pcs_regs.svh */
// Purpose: Offsets, fields, reset values and counts of the clock source
//          select block.
// Assumes: 32-bit APB data, one register per aligned word.
// Notes:   Included by the package and the design file.
`ifndef PCS_REGS_SVH
`define PCS_REGS_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define PCS_OFS_SEL1 12'h014
`define PCS_OFS_SEL2 12'h01C
`define PCS_OFS_UNLOCK 12'h100

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define PCS_TMR0_HI 10
`define PCS_TMR0_LO 8
`define PCS_ADC_HI 3
`define PCS_ADC_LO 2
`define PCS_WDT_HI 1
`define PCS_WDT_LO 0
`define PCS_PWM67_HI 7
`define PCS_PWM67_LO 6
`define PCS_PWM45_HI 5
`define PCS_PWM45_LO 4
`define PCS_FRQ_HI 3
`define PCS_FRQ_LO 2
`define PCS_I2S_HI 1
`define PCS_I2S_LO 0

// ----------------------------------------------------------------------
// Writable masks and reset values
// ----------------------------------------------------------------------
`define PCS_SEL1_MASK 32'h0000_070C
`define PCS_SEL1_RST 32'h0000_070F
`define PCS_SEL2_MASK_MED 32'h0000_00FF
`define PCS_SEL2_MASK_LOW 32'h0000_000F
`define PCS_SEL2_RST_MED 32'h0000_00F0
`define PCS_SEL2_RST_LOW 32'h0000_00FF

// ----------------------------------------------------------------------
// Unlock key bytes and watchdog divider
// ----------------------------------------------------------------------
`define PCS_KEY1 8'h59
`define PCS_KEY2 8'h16
`define PCS_KEY3 8'h88
`define PCS_WDT_DIV 2048
`define PCS_WDT_HALF 10'h3FF

`endif

/* rtl/pcs_top.sv */
// Purpose: Peripheral clock source selection with APB registers.
// Assumes: clk_in is the core bus clock; source inputs are synchronous levels.
// Notes:   Selected clocks leave as registered levels, one cycle late.
//          The watchdog field is guarded by a three byte key sequence.
//          The low density build has no PWM pair clocks.
`timescale 1ns/1ps
`default_nettype none
`include "pcs_regs.svh"

module pcs_top #(
  // Low density build: no PWM pair clocks, other second-register reset
  parameter bit LOW_DENSITY = 1'b0
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  // Candidate clock source levels
  input wire pcs_pkg::pcs_src_t src_in,
  // APB answer, selected clocks and lock state
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output pcs_pkg::pcs_clk_t clk_sel_out,
  output logic unlocked_out
);

  // State, the copy being built, and decode helpers
  pcs_pkg::pcs_state_t s_q;
  pcs_pkg::pcs_state_t s_d;
  logic [31:0] sel2_mask;
  logic [31:0] sel2_rst;
  logic access;
  logic commit;
  logic mapped;
  logic [31:0] rd_val;
  logic [31:0] wr_val;
  logic hit_sel1;
  logic hit_sel2;
  logic hit_key;
  logic wr_sel1;
  logic wr_sel2;
  logic wr_key;
  logic [7:0] key_byte;

  // ----------------------------------------------------------------------
  // Source pickers
  // ----------------------------------------------------------------------

  // Four-way pick shared by the pair, divider and audio fields
  // Codes 00 to 11 take the first to the fourth source in turn
  function automatic logic pick4(input logic [1:0] code, input logic s0,
                                 input logic s1, input logic s2,
                                 input logic s3);
    logic r;
    r = 1'b0;
    unique case (code)
      2'b00: r = s0;
      2'b01: r = s1;
      2'b10: r = s2;
      2'b11: r = s3;
    endcase
    return r;
  endfunction : pick4

  // Timer source: any code with the top bit set takes the oscillator
  function automatic logic pick_timer(input logic [2:0] code,
                                      input pcs_pkg::pcs_src_t s);
    logic r;
    r = s.osc_22m;
    if (!code[2])
    begin
      r = pick4(code[1:0], s.xtal_main, s.xtal_32k, s.bus_clk, s.ext_trig);
    end
    return r;
  endfunction : pick_timer

  // Variant dependent layout of the second select register
  assign sel2_mask = LOW_DENSITY ? `PCS_SEL2_MASK_LOW : `PCS_SEL2_MASK_MED;
  assign sel2_rst = LOW_DENSITY ? `PCS_SEL2_RST_LOW : `PCS_SEL2_RST_MED;

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------

  // Access phase and the edge at which it completes
  assign access = psel_in && penable_in;
  assign commit = access && s_q.rsp.pready;
  assign mapped = hit_sel1 || hit_sel2 || hit_key;

  // Address hits, one per register
  assign hit_sel1 = (paddr_in == `PCS_OFS_SEL1);
  assign hit_sel2 = (paddr_in == `PCS_OFS_SEL2);
  assign hit_key = (paddr_in == `PCS_OFS_UNLOCK);

  // Write strobes, live only at the completing edge
  assign wr_sel1 = commit && pwrite_in && hit_sel1;
  assign wr_sel2 = commit && pwrite_in && hit_sel2;
  assign wr_key = commit && pwrite_in && hit_key;
  assign key_byte = wr_val[7:0];

  // Read view of the registers
  // Unmapped addresses read as zero
  always_comb
  begin
    rd_val = 32'h0000_0000;
    wr_val = 32'h0000_0000;
    if (paddr_in == `PCS_OFS_SEL1)
    begin
      rd_val = s_q.sel1;
    end
    else if (paddr_in == `PCS_OFS_SEL2)
    begin
      rd_val = s_q.sel2;
    end
    else if (paddr_in == `PCS_OFS_UNLOCK)
    begin
      rd_val = {31'h0000_0000, s_q.lock == pcs_pkg::PCS_OPEN};
    end
    wr_val = pwdata_in;
  end

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    // Hold everything unless a rule below moves it
    s_d = s_q;

    // ------------------------------------------------------------
    // Bus answer
    // ------------------------------------------------------------

    // Two-cycle access: ready rises one cycle into the access phase
    s_d.rsp.pready = access && !s_q.rsp.pready;
    s_d.rsp.pslverr = access && !s_q.rsp.pready && !mapped;
    s_d.rsp.prdata = 32'h0000_0000;
    if (access && !s_q.rsp.pready && !pwrite_in)
    begin
      s_d.rsp.prdata = rd_val;
    end

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------

    // First select register; keep the protected field unless open
    if (wr_sel1)
    begin
      s_d.sel1 = wr_val & `PCS_SEL1_MASK;
      s_d.sel1[`PCS_WDT_HI:`PCS_WDT_LO] =
        s_q.sel1[`PCS_WDT_HI:`PCS_WDT_LO];
      if (s_q.lock == pcs_pkg::PCS_OPEN)
      begin
        s_d.sel1[`PCS_WDT_HI:`PCS_WDT_LO] =
          wr_val[`PCS_WDT_HI:`PCS_WDT_LO];
      end
    end

    // Second select register; fixed bits keep their reset level
    if (wr_sel2)
    begin
      s_d.sel2 = (wr_val & sel2_mask) | (sel2_rst & ~sel2_mask);
    end

    // ------------------------------------------------------------
    // Unlock sequence
    // ------------------------------------------------------------

    // A wrong byte restarts at locked; any write once open relocks
    if (wr_key)
    begin
      unique case (s_q.lock)
        pcs_pkg::PCS_LOCKED:
        begin
          if (key_byte == `PCS_KEY1)
          begin
            s_d.lock = pcs_pkg::PCS_KEY1_SEEN;
          end
          else
          begin
            s_d.lock = pcs_pkg::PCS_LOCKED;
          end
        end
        pcs_pkg::PCS_KEY1_SEEN:
        begin
          if (key_byte == `PCS_KEY2)
          begin
            s_d.lock = pcs_pkg::PCS_KEY2_SEEN;
          end
          else
          begin
            s_d.lock = pcs_pkg::PCS_LOCKED;
          end
        end
        pcs_pkg::PCS_KEY2_SEEN:
        begin
          if (key_byte == `PCS_KEY3)
          begin
            s_d.lock = pcs_pkg::PCS_OPEN;
          end
          else
          begin
            s_d.lock = pcs_pkg::PCS_LOCKED;
          end
        end
        pcs_pkg::PCS_OPEN:
        begin
          s_d.lock = pcs_pkg::PCS_LOCKED;
        end
        default:
        begin
          s_d.lock = pcs_pkg::PCS_LOCKED;
        end
      endcase
    end

    // ------------------------------------------------------------
    // Divided watchdog clock
    // ------------------------------------------------------------

    // Bus clock divided by 2048: toggle every 1024 cycles
    // Free running from reset, so its phase is unrelated to selects
    s_d.div_cnt = s_q.div_cnt + 10'h001;
    if (s_q.div_cnt == `PCS_WDT_HALF)
    begin
      s_d.div_cnt = 10'h000;
      s_d.div_clk = !s_q.div_clk;
    end

    // ------------------------------------------------------------
    // Source multiplexers
    // ------------------------------------------------------------

    // Timer 0: top code bit set takes the oscillator
    s_d.clk.timer0 = pick_timer(s_q.sel1[`PCS_TMR0_HI:`PCS_TMR0_LO],
                                src_in);

    // Converter: upper code bit set takes the oscillator
    s_d.clk.adc = pick4(s_q.sel1[`PCS_ADC_HI:`PCS_ADC_LO], src_in.xtal_main,
                        src_in.pll, src_in.osc_22m, src_in.osc_22m);

    // Reserved watchdog code gives a quiet low clock
    s_d.clk.watchdog = pick4(s_q.sel1[`PCS_WDT_HI:`PCS_WDT_LO],
                             src_in.xtal_main, 1'b0, s_q.div_clk,
                             src_in.osc_10k);

    // One engine clock per PWM pair, absent in the low density variant
    s_d.clk.pwm67 = !LOW_DENSITY &&
                    pick4(s_q.sel2[`PCS_PWM67_HI:`PCS_PWM67_LO],
                          src_in.xtal_main, src_in.xtal_32k, src_in.bus_clk,
                          src_in.osc_22m);
    s_d.clk.pwm45 = !LOW_DENSITY &&
                    pick4(s_q.sel2[`PCS_PWM45_HI:`PCS_PWM45_LO],
                          src_in.xtal_main, src_in.xtal_32k, src_in.bus_clk,
                          src_in.osc_22m);

    // Divider output source
    s_d.clk.freq_div = pick4(s_q.sel2[`PCS_FRQ_HI:`PCS_FRQ_LO],
                             src_in.xtal_main, src_in.xtal_32k,
                             src_in.bus_clk, src_in.osc_22m);

    // Audio interface source
    s_d.clk.audio = pick4(s_q.sel2[`PCS_I2S_HI:`PCS_I2S_LO],
                          src_in.xtal_main, src_in.pll, src_in.bus_clk,
                          src_in.osc_22m);
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  // Synchronous reset loads the reset values and locks the key
  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      // Answer, divider and clocks clear to zero
      s_q <= '0;
      s_q.sel1 <= `PCS_SEL1_RST;
      s_q.sel2 <= LOW_DENSITY ? `PCS_SEL2_RST_LOW :
                                `PCS_SEL2_RST_MED;
      s_q.lock <= pcs_pkg::PCS_LOCKED;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state flops
  assign prdata_out = s_q.rsp.prdata;
  assign pready_out = s_q.rsp.pready;
  assign pslverr_out = s_q.rsp.pslverr;
  assign clk_sel_out = s_q.clk;
  // Open is the top bit of the one-hot lock code
  assign unlocked_out = s_q.lock[3];

endmodule : pcs_top
`default_nettype wire

/* tb/pcs_monitor.sv */
// Purpose: Port checks of the clock source select block.
// Assumes: Bound into pcs_top.
// Notes:   Bus answer, lock level and mux relations.
`timescale 1ns/1ps
`default_nettype none
module pcs_monitor (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire pcs_pkg::pcs_src_t src_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire pcs_pkg::pcs_clk_t clk_sel_out,
  input wire logic unlocked_out
);
  // ----------------------------------------
  // Helpers and assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);
  logic map_w;
  logic key_w;
  // Mapped address and a taken write to the unlock register
  assign map_w = paddr_in inside {12'h014, 12'h01C, 12'h100};
  assign key_w = psel_in && penable_in && pready_out && pwrite_in &&
    paddr_in == 12'h100;
  a_ready_pulse: assert property (pready_out |=> !pready_out)
    else $error("ready longer than one cycle");
  a_ready_access: assert property (psel_in && $rose(penable_in) |=> pready_out)
    else $error("no answer after access start");
  a_err_unmapped: assert property (pready_out && !map_w |-> pslverr_out)
    else $error("unmapped access not flagged");
  a_err_mapped: assert property (pready_out && map_w |-> !pslverr_out)
    else $error("mapped access flagged");
  a_idle_data: assert property (!pready_out |-> prdata_out == 32'h0)
    else $error("read data outside answer");
  a_unlock_rise: assert property ($rose(unlocked_out) |->
    $past(key_w && pwdata_in[7:0] == 8'h88))
    else $error("unlock without final key");
  a_unlock_fall: assert property ($fell(unlocked_out) |->
    $past(key_w) || $past(reset_in))
    else $error("relock without cause");
  a_src_zero: assert property (src_in == 7'h0 |=>
    (clk_sel_out & 7'h6F) == 7'h0)
    else $error("clock out with no source");
  a_reset_clear: assert property (disable iff (1'b0) reset_in |=>
    clk_sel_out == 7'h0 && !unlocked_out)
    else $error("reset does not clear outputs");
endmodule : pcs_monitor
`default_nettype wire

/* tb/pcs_top_tb.sv */
// Purpose: Directed register and mux test of pcs_top.
// Assumes: Medium density build.
// Notes:   Sources are probed one-hot, then all but one.
`timescale 1ns/1ps
`default_nettype none
module pcs_top_tb;
  logic clk_in, reset_in, psel_in, penable_in, pwrite_in, er, wd;
  logic pready_out, pslverr_out, unlocked_out;
  logic [11:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out, rd;
  pcs_pkg::pcs_src_t src_in;
  pcs_pkg::pcs_clk_t clk_sel_out;
  int n_errors = 0;
  int samples_checked = 0;
  int i, c, k;
  int s1[8] = '{6, 5, 4, 1, 2, 2, 2, 2};
  int s2[4] = '{6, 3, 2, 2};
  int s3[4] = '{6, 5, 4, 2};
  int s4[4] = '{6, 3, 4, 2};
  pcs_top u_pcs_top (.clk_in, .reset_in, .psel_in, .penable_in,
    .pwrite_in, .paddr_in, .pwdata_in, .src_in, .prdata_out,
    .pready_out, .pslverr_out, .clk_sel_out, .unlocked_out);
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic print_verdict;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR %0t seen %h want %h", $time, seen, exp);
    end
  endtask : chk
  // One APB transfer, held until ready is seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge clk_in);
    psel_in <= 1'b1;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    for (k = 0; k < 9; k++)
    begin
      @(posedge clk_in);
      if (pready_out === 1'b1)
        break;
    end
    rd = prdata_out;
    er = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    if (k == 9)
    begin
      chk(32'h1, 32'h0);
      print_verdict();
    end
  endtask : apb
  // Selected outputs in mask m must follow source bit s only
  task automatic probe(input logic [6:0] m, input int s);
    src_in <= 7'(1 << s);
    repeat (3) @(posedge clk_in);
    chk(32'(clk_sel_out & m), 32'(m));
    src_in <= ~7'(1 << s);
    repeat (3) @(posedge clk_in);
    chk(32'(clk_sel_out & m), 32'h0);
  endtask : probe
  task automatic wait_flip;
    wd = clk_sel_out.watchdog;
    for (i = 1; i < 2100; i++)
    begin
      @(posedge clk_in);
      if (clk_sel_out.watchdog !== wd)
        break;
    end
    if (i == 2100)
    begin
      chk(32'h1, 32'h0);
      print_verdict();
    end
  endtask : wait_flip
  // Clock
  initial
  begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    {reset_in, psel_in, penable_in, pwrite_in} = 4'hF;
    {psel_in, penable_in, pwrite_in} = 3'h0;
    paddr_in = 12'h0;
    pwdata_in = 32'h0;
    src_in = 7'h0;
    repeat (5) @(posedge clk_in);
    reset_in <= 1'b0;
    apb(1'b0, 12'h014, 32'h0);
    chk(rd, 32'h0000_070F);
    apb(1'b0, 12'h01C, 32'h0);
    chk(rd, 32'h0000_00F0);
    apb(1'b1, 12'h040, 32'h1);
    chk(32'(er), 32'h1);
    $display("test reset done");
    for (c = 0; c < 8; c++)
    begin
      apb(1'b1, 12'h014, 32'(c << 8) | 32'h3);
      probe(7'h40, s1[c]);
    end
    for (c = 0; c < 4; c++)
    begin
      apb(1'b1, 12'h014, 32'(c << 2));
      probe(7'h20, s2[c]);
    end
    apb(1'b0, 12'h014, 32'h0);
    chk(rd, 32'h0000_000F);
    probe(7'h10, 0);
    for (c = 0; c < 4; c++)
    begin
      apb(1'b1, 12'h01C, 32'(c * 8'h55));
      probe(7'h0E, s3[c]);
      probe(7'h01, s4[c]);
    end
    $display("test select done");
    apb(1'b1, 12'h100, 32'h59);
    apb(1'b1, 12'h100, 32'h00);
    apb(1'b1, 12'h100, 32'h88);
    chk(32'(unlocked_out), 32'h0);
    apb(1'b0, 12'h100, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, 12'h100, 32'h59);
    apb(1'b1, 12'h100, 32'h16);
    apb(1'b1, 12'h100, 32'h88);
    apb(1'b0, 12'h100, 32'h0);
    chk(32'(rd[0]), 32'h1);
    chk(32'(unlocked_out), 32'h1);
    apb(1'b1, 12'h014, 32'h0);
    probe(7'h10, 6);
    apb(1'b1, 12'h014, 32'h1);
    src_in <= 7'h7F;
    repeat (3) @(posedge clk_in);
    chk(32'(clk_sel_out.watchdog), 32'h0);
    apb(1'b1, 12'h014, 32'h2);
    // First flip may be the select change itself, so measure the third
    wait_flip();
    wait_flip();
    wait_flip();
    chk(i, 1024);
    apb(1'b1, 12'h100, 32'h0);
    apb(1'b1, 12'h014, 32'h3);
    apb(1'b0, 12'h014, 32'h0);
    chk(rd, 32'h0000_0002);
    $display("test watchdog done");
    print_verdict();
  end
endmodule : pcs_top_tb
bind pcs_top pcs_monitor u_pcs_monitor (.clk_in, .reset_in, .psel_in,
  .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .src_in, .prdata_out,
  .pready_out, .pslverr_out, .clk_sel_out, .unlocked_out);
`default_nettype wire
